//--- sibad_decode.sv
// module: mod/rm plus s-i-b effective address decoder, registered outputs
// Summary of operation
// RL1: scale code picks multiplier 1,2,4,8
// RL2: scaled index is an offset addend
// RL3: index code picks register, 100 none
// RL4: no index needs scale 00 for defined address
// RL5: sib present means mod plus base decide
// RL6: mod sets displacement; mod00 base101 takes dword
// RL7: base picks register and default segment
// RL8: base plus index costs one extra clock
// RL9: single register with scaling adds nothing
// RL10: rm 100 under mod 00/01/10 means sib
// RL11: offset truncated to 32 bits
`timescale 1ns/1ps
module sibad_decode
   import sibad_pkg::*;
#(
   parameter int ADDR_W = SIBAD_ADDR_W
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic [7:0] modrm,
   input wire logic [7:0] sib,
   input wire logic [ADDR_W-1:0] gpr_eax,
   input wire logic [ADDR_W-1:0] gpr_ecx,
   input wire logic [ADDR_W-1:0] gpr_edx,
   input wire logic [ADDR_W-1:0] gpr_ebx,
   input wire logic [ADDR_W-1:0] gpr_esp,
   input wire logic [ADDR_W-1:0] gpr_ebp,
   input wire logic [ADDR_W-1:0] gpr_esi,
   input wire logic [ADDR_W-1:0] gpr_edi,
   input wire logic [ADDR_W-1:0] byte_displacement,
   input wire logic [ADDR_W-1:0] dword_displacement,
   output logic out_valid,
   output logic sib_present,
   output logic [ADDR_W-1:0] ea_offset,
   output logic seg_is_ss,
   output logic [1:0] disp_size,
   output logic [3:0] scale_factor,
   output logic has_base,
   output logic [2:0] base_sel,
   output logic has_index,
   output logic [2:0] index_sel,
   output logic ea_undefined,
   output logic extra_clock
);
   logic [1:0] mod_f;
   logic [2:0] rm_f;
   logic [1:0] ss_f;
   logic [2:0] idx_f;
   logic [2:0] base_f;
   logic sib_now;
   logic base_use;
   logic idx_use;
   logic ss_seg;
   sibad_disp_e disp_kind;
   logic [1:0] shift;
   logic [ADDR_W-1:0] base_v;
   logic [ADDR_W-1:0] idx_v;
   logic [ADDR_W-1:0] disp_v;
   logic [ADDR_W-1:0] sum;

   function automatic logic [ADDR_W-1:0] gpr_pick(input logic [2:0] sel);
      logic [ADDR_W-1:0] v;
      v = gpr_eax;
      unique case (sel)
         SIBAD_REG_EAX: v = gpr_eax;
         SIBAD_REG_ECX: v = gpr_ecx;
         SIBAD_REG_EDX: v = gpr_edx;
         SIBAD_REG_EBX: v = gpr_ebx;
         SIBAD_REG_ESP: v = gpr_esp;
         SIBAD_REG_EBP: v = gpr_ebp;
         SIBAD_REG_ESI: v = gpr_esi;
         SIBAD_REG_EDI: v = gpr_edi;
      endcase
      return v;
   endfunction

   // displacement size from mod alone, for forms with a base register
   function automatic sibad_disp_e disp_of(input logic [1:0] md);
      sibad_disp_e k;
      // mod 00 and mod 11 both give none; no-base forms are handled by the caller
      k = SIBAD_DISP_NONE;
      if (md == SIBAD_MOD_DISP8) begin
         k = SIBAD_DISP_BYTE;
      end else if (md == SIBAD_MOD_DISP32) begin
         k = SIBAD_DISP_DWORD;
      end
      return k;
   endfunction

   // sib fields are split always; they mean nothing unless sib_now
   assign mod_f = modrm[SIBAD_HI_MSB:SIBAD_HI_LSB];
   assign rm_f = modrm[SIBAD_LO_MSB:SIBAD_LO_LSB];
   assign ss_f = sib[SIBAD_HI_MSB:SIBAD_HI_LSB];
   assign idx_f = sib[SIBAD_MID_MSB:SIBAD_MID_LSB];
   assign base_f = sib[SIBAD_LO_MSB:SIBAD_LO_LSB];

   // memory forms only; register form mod 11 never carries a sib byte
   assign sib_now = (mod_f != SIBAD_MOD_REG) && (rm_f == SIBAD_RM_SIB); // [RL10]

   always_comb begin
      unique case (ss_f)
         SIBAD_SS_X1: shift = SIBAD_SHIFT_X1; // [RL1]
         SIBAD_SS_X2: shift = SIBAD_SHIFT_X2; // [RL1]
         SIBAD_SS_X4: shift = SIBAD_SHIFT_X4; // [RL1]
         SIBAD_SS_X8: shift = SIBAD_SHIFT_X8; // [RL1]
      endcase
   end

   always_comb begin
      base_use = 1'b1;
      idx_use = 1'b0;
      ss_seg = 1'b0;
      disp_kind = SIBAD_DISP_NONE;
      base_v = SIBAD_ZERO32;
      idx_v = SIBAD_ZERO32;
      disp_v = SIBAD_ZERO32;
      if (sib_now) begin
         // recipe from mod and base, rm ignored
         idx_use = (idx_f != SIBAD_IDX_NONE); // [RL3] [RL5]
         idx_v = idx_use ? gpr_pick(idx_f) : SIBAD_ZERO32; // [RL3]
         if (mod_f == SIBAD_MOD_NODISP && base_f == SIBAD_BASE_EBP) begin
            base_use = 1'b0; // [RL7]
            disp_kind = SIBAD_DISP_DWORD; // [RL6]
         end else begin
            base_v = gpr_pick(base_f); // [RL7]
            ss_seg = (base_f == SIBAD_BASE_ESP) || (base_f == SIBAD_BASE_EBP); // [RL7]
            // under mod 01/10 base 101 is a real base register
            disp_kind = disp_of(mod_f); // [RL6]
         end
      end else if (mod_f == SIBAD_MOD_NODISP && rm_f == SIBAD_RM_DISP32) begin
         // no base register, dword displacement alone
         base_use = 1'b0;
         disp_kind = SIBAD_DISP_DWORD;
      end else begin
         // plain single register forms, and mod 11 register operand
         // mod 11 offset is only the register; consumers take the register itself
         base_v = gpr_pick(rm_f);
         ss_seg = (rm_f == SIBAD_REG_EBP) && (mod_f != SIBAD_MOD_NODISP);
         disp_kind = disp_of(mod_f);
      end
      unique case (disp_kind)
         SIBAD_DISP_NONE: disp_v = SIBAD_ZERO32;
         // sign-extend the low byte
         SIBAD_DISP_BYTE: disp_v = {{(ADDR_W-SIBAD_DISP8_W){byte_displacement[SIBAD_DISP8_W-1]}},
                                    byte_displacement[SIBAD_DISP8_W-1:0]}; // [RL11]
         SIBAD_DISP_DWORD: disp_v = dword_displacement;
         default: disp_v = SIBAD_ZERO32;
      endcase
   end

   sibad_agu #(
      .ADDR_W(ADDR_W)
   ) u_agu (
      .base_val(base_v),
      .index_val(idx_v),
      .scale_shift(sib_now ? shift : SIBAD_SHIFT_X1),
      .disp_val(disp_v),
      .offset(sum)
   );

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         out_valid <= 1'b0;
      end else begin
         out_valid <= req_valid;
      end
   end

   // recipe: which registers and segment the datapath will need
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         sib_present <= 1'b0;
         seg_is_ss <= 1'b0;
         disp_size <= SIBAD_DISP_NONE;
         has_base <= 1'b0;
         base_sel <= SIBAD_SEL_ZERO;
      end else if (req_valid) begin
         sib_present <= sib_now; // [RL10]
         seg_is_ss <= ss_seg; // [RL7]
         disp_size <= disp_kind; // [RL6]
         has_base <= base_use; // [RL7]
         base_sel <= sib_now ? base_f : rm_f; // [RL5]
      end
   end

   // offset on its own: the long adder path ends here
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ea_offset <= SIBAD_ZERO32;
      end else if (req_valid) begin
         ea_offset <= sum; // [RL2] [RL11]
      end
   end

   // scale reads one outside sib forms so a consumer may multiply blindly
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         scale_factor <= SIBAD_SCALE_ONE;
         has_index <= 1'b0;
         index_sel <= SIBAD_SEL_ZERO;
      end else if (req_valid) begin
         scale_factor <= SIBAD_SCALE_ONE << (sib_now ? shift : SIBAD_SHIFT_X1); // [RL1]
         has_index <= idx_use; // [RL3]
         index_sel <= idx_f; // [RL3]
      end
   end

   // flags kept separate: timing and validity concerns
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ea_undefined <= 1'b0;
         extra_clock <= 1'b0;
      end else if (req_valid) begin
         // no index with nonzero scale: address not guaranteed
         ea_undefined <= sib_now && !idx_use && (ss_f != SIBAD_SS_X1); // [RL4]
         // two registers cost a clock; one register plus scale is free
         extra_clock <= (base_use && idx_use) ? SIBAD_EXTRA_CLK : 1'b0; // [RL8] [RL9]
      end
   end
endmodule // sibad_decode

//--- sibad_pkg.sv
// package: constants and types for the sib address decoder
package sibad_pkg;
   localparam int SIBAD_ADDR_W = 32;
   localparam logic [1:0] SIBAD_SS_X1 = 2'h0;
   localparam logic [1:0] SIBAD_SS_X2 = 2'h1;
   localparam logic [1:0] SIBAD_SS_X4 = 2'h2;
   localparam logic [1:0] SIBAD_SS_X8 = 2'h3;
   localparam logic [1:0] SIBAD_SHIFT_X1 = 2'h0;
   localparam logic [1:0] SIBAD_SHIFT_X2 = 2'h1;
   localparam logic [1:0] SIBAD_SHIFT_X4 = 2'h2;
   localparam logic [1:0] SIBAD_SHIFT_X8 = 2'h3;
   localparam logic [1:0] SIBAD_MOD_NODISP = 2'h0;
   localparam logic [1:0] SIBAD_MOD_DISP8 = 2'h1;
   localparam logic [1:0] SIBAD_MOD_DISP32 = 2'h2;
   localparam logic [1:0] SIBAD_MOD_REG = 2'h3;
   localparam logic [2:0] SIBAD_RM_SIB = 3'h4;
   localparam logic [2:0] SIBAD_RM_DISP32 = 3'h5;
   localparam logic [2:0] SIBAD_IDX_NONE = 3'h4;
   localparam logic [2:0] SIBAD_BASE_ESP = 3'h4;
   localparam logic [2:0] SIBAD_BASE_EBP = 3'h5;
   localparam logic [2:0] SIBAD_REG_EBP = 3'h5;
   localparam logic [2:0] SIBAD_REG_EAX = 3'h0;
   localparam logic [2:0] SIBAD_REG_ECX = 3'h1;
   localparam logic [2:0] SIBAD_REG_EDX = 3'h2;
   localparam logic [2:0] SIBAD_REG_EBX = 3'h3;
   localparam logic [2:0] SIBAD_REG_ESP = 3'h4;
   localparam logic [2:0] SIBAD_REG_ESI = 3'h6;
   localparam logic [2:0] SIBAD_REG_EDI = 3'h7;
   localparam logic [3:0] SIBAD_SCALE_ONE = 4'h1;
   localparam logic [2:0] SIBAD_SEL_ZERO = 3'h0;
   localparam int SIBAD_HI_MSB = 7;
   localparam int SIBAD_HI_LSB = 6;
   localparam int SIBAD_MID_MSB = 5;
   localparam int SIBAD_MID_LSB = 3;
   localparam int SIBAD_LO_MSB = 2;
   localparam int SIBAD_LO_LSB = 0;
   localparam int SIBAD_DISP8_W = 8;
   localparam logic [0:0] SIBAD_EXTRA_CLK = 1'h1;
   localparam logic [31:0] SIBAD_ZERO32 = 32'h0000_0000;
   typedef enum logic [1:0] {
      SIBAD_DISP_NONE,
      SIBAD_DISP_BYTE,
      SIBAD_DISP_DWORD
   } sibad_disp_e;
   typedef enum logic [1:0] {
      SIBAD_SEG_DS,
      SIBAD_SEG_SS
   } sibad_seg_e;
endpackage

//--- sibad_agu.sv
// module: scaled-index offset adder
`timescale 1ns/1ps
module sibad_agu
   import sibad_pkg::*;
#(
   parameter int ADDR_W = SIBAD_ADDR_W
) (
   input wire logic [ADDR_W-1:0] base_val,
   input wire logic [ADDR_W-1:0] index_val,
   input wire logic [1:0] scale_shift,
   input wire logic [ADDR_W-1:0] disp_val,
   output logic [ADDR_W-1:0] offset
);
   logic [ADDR_W-1:0] scaled;
   // shift by 0..3 is multiply by 1/2/4/8; upper bits drop on purpose
   assign scaled = index_val << scale_shift; // [RL2]
   // carries out of the top bit are discarded
   assign offset = base_val + scaled + disp_val; // [RL11]
endmodule // sibad_agu

//--- sibad_properties.sv
// checker: port properties of the sib address decoder
`timescale 1ns/1ps
module sibad_properties
   import sibad_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic [7:0] modrm,
   input wire logic [7:0] sib,
   input wire logic out_valid,
   input wire logic sib_present,
   input wire logic [3:0] scale_factor,
   input wire logic has_index,
   input wire logic has_base,
   input wire logic seg_is_ss,
   input wire logic [1:0] disp_size,
   input wire logic ea_undefined,
   input wire logic extra_clock
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   logic [7:0] mr_r;
   logic [7:0] sb_r;
   wire sib_req = req_valid && modrm[2:0] == 3'h4 && modrm[7:6] != 2'h3;
   wire plain_req = req_valid && !(modrm[2:0] == 3'h4 && modrm[7:6] != 2'h3);
   wire [1:0] m = mr_r[7:6];
   wire [2:0] b = sb_r[2:0];
   wire [2:0] x = sb_r[5:3];
   // request bytes held one cycle to line up with the registered answer
   always_ff @(posedge ref_clk) begin
      mr_r <= modrm;
      sb_r <= sib;
   end
   sequence s_sib_taken;
      sib_req ##1 out_valid;
   endsequence
   property p_present; sib_req |=> out_valid && sib_present; endproperty
   property p_scale; s_sib_taken |-> scale_factor == 4'h1 << sb_r[7:6]; endproperty
   property p_index; s_sib_taken |-> has_index == (x != 3'h4); endproperty
   property p_undef; sib_req |=> ea_undefined == (x == 3'h4 && sb_r[7:6] != 2'h0); endproperty
   property p_disp;
      s_sib_taken |-> disp_size == (m == 2'h1 ? 2'h1 : (m == 2'h2 || b == 3'h5) ? 2'h2 : 2'h0);
   endproperty
   property p_seg; sib_req |=> seg_is_ss == (b == 3'h4 || b == 3'h5 && m != 2'h0); endproperty
   property p_base; sib_req |=> has_base == !(b == 3'h5 && m == 2'h0); endproperty
   property p_extra;
      s_sib_taken |-> extra_clock == (x != 3'h4 && !(b == 3'h5 && m == 2'h0));
   endproperty
   property p_plain; plain_req |=> out_valid && !sib_present && !has_index; endproperty
   property p_single; plain_req |=> !extra_clock; endproperty
   a_present: assert property (p_present) else $error("sib byte not flagged");
   a_scale: assert property (p_scale) else $error("scale factor wrong");
   a_index: assert property (p_index) else $error("index presence wrong");
   a_undef: assert property (p_undef) else $error("undefined flag wrong");
   a_disp: assert property (p_disp) else $error("displacement size wrong");
   a_seg: assert property (p_seg) else $error("default segment wrong");
   a_base: assert property (p_base) else $error("base presence wrong");
   a_extra: assert property (p_extra) else $error("extra clock wrong");
   a_plain: assert property (p_plain) else $error("sib flagged without sib byte");
   a_single: assert property (p_single) else $error("extra clock on one register");
endmodule // sibad_properties
bind sibad_decode sibad_properties i_props (.ref_clk, .reset, .req_valid, .modrm, .sib,
   .out_valid, .sib_present, .scale_factor, .has_index, .has_base, .seg_is_ss, .disp_size,
   .ea_undefined, .extra_clock);

//--- sibad_gpr_model.sv
// partner: register file values seen by the address decoder
`timescale 1ns/1ps
module sibad_gpr_model (
   output logic [31:0] gpr [8]
);
   // large multiples of one odd constant so scaled sums differ and the top one wraps
   for (genvar i = 0; i < 8; i++) begin : g_reg
      assign gpr[i] = 32'(32'h2468_ace1 * (i + 1));
   end
endmodule // sibad_gpr_model

//--- sib_address_decode_tb_top.sv
// testbench: sib address decoder
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value t=%0t got %h exp %h", $time, a, e); end end
module sib_address_decode_tb_top import sibad_pkg::*;;
   logic ref_clk = 1'h0, reset = 1'h1, req_valid = 1'h0;
   logic [7:0] modrm = 8'h00, sib = 8'h00;
   logic [31:0] gpr [8];
   logic [31:0] byte_disp = 32'h0000_00fc, dword_disp = 32'h8000_0010, ea_offset;
   logic [2:0] base_sel, index_sel;
   logic out_valid, sib_present, seg_is_ss, has_base, has_index, ea_undefined, extra_clock;
   logic [1:0] disp_size;
   logic [3:0] scale_factor;
   int miscompares = 0, checked = 0, cycles = 0;
   sibad_gpr_model i_gpr (.gpr);
   sibad_decode i_dut (.ref_clk, .reset, .req_valid, .modrm, .sib, .gpr_eax(gpr[0]),
      .gpr_ecx(gpr[1]), .gpr_edx(gpr[2]), .gpr_ebx(gpr[3]), .gpr_esp(gpr[4]), .gpr_ebp(gpr[5]),
      .gpr_esi(gpr[6]), .gpr_edi(gpr[7]), .byte_displacement(byte_disp),
      .dword_displacement(dword_disp),
      .out_valid, .sib_present, .ea_offset, .seg_is_ss, .disp_size, .scale_factor, .has_base,
      .base_sel, .has_index, .index_sel, .ea_undefined, .extra_clock);
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk) if (++cycles > 2000) begin
      miscompares++;
      report_and_stop();
   end
   task automatic go(input logic [7:0] m, input logic [7:0] s);
      @(posedge ref_clk) #1;
      req_valid = 1'h1; modrm = m; sib = s;
      @(posedge ref_clk) #1;
      req_valid = 1'h0;
      `CHK(out_valid, 1'h1)
   endtask
   function automatic logic [1:0] dsz(input logic [7:0] m, input logic [7:0] s);
      if (m[7:6] == 2'h1) return SIBAD_DISP_BYTE;
      if (m[7:6] == 2'h2 || s[2:0] == 3'h5) return SIBAD_DISP_DWORD;
      return SIBAD_DISP_NONE;
   endfunction
   function automatic logic [31:0] ea(input logic [7:0] m, input logic [7:0] s);
      logic [31:0] r = (m[7:6] == 2'h0 && s[2:0] == 3'h5) ? 32'h0000_0000 : gpr[s[2:0]];
      if (s[5:3] != 3'h4) r += gpr[s[5:3]] << s[7:6];
      if (m[7:6] == 2'h1) r += {{24{byte_disp[7]}}, byte_disp[7:0]};
      else if (m[7:6] == 2'h2 || s[2:0] == 3'h5) r += dword_disp;
      return r;
   endfunction
   task automatic t_scale();
      for (int q = 0; q < 4; q++) begin
         go(8'h44, {q[1:0], 6'h08});
         `CHK(scale_factor, 4'h1 << q)
         `CHK(ea_offset, ea(8'h44, {q[1:0], 6'h08}))
         `CHK(extra_clock, 1'h1)
      end
      $display("t_scale done");
   endtask
   task automatic t_base();
      for (int k = 0; k < 24; k++) begin
         go({k[4:3], 6'h04}, {5'h04, k[2:0]});
         `CHK(ea_offset, ea({k[4:3], 6'h04}, {5'h04, k[2:0]}))
         `CHK(seg_is_ss, 1'(k[2:0] == 3'h4 || k[2:0] == 3'h5 && k[4:3] != 2'h0))
         `CHK(extra_clock, 1'h0)
         `CHK(sib_present, 1'h1)
         `CHK(disp_size, dsz({k[4:3], 6'h04}, {5'h04, k[2:0]}))
         `CHK(has_base, 1'(!(k[2:0] == 3'h5 && k[4:3] == 2'h0)))
         `CHK(base_sel, k[2:0])
         `CHK(has_index, 1'h0)
         `CHK(ea_undefined, 1'h0)
      end
      $display("t_base done");
   endtask
   task automatic t_index();
      for (int j = 0; j < 8; j++) begin
         go(8'h84, {2'h3, j[2:0], 3'h6});
         `CHK(has_index, 1'(j != 4))
         `CHK(index_sel, j[2:0])
         `CHK(ea_offset, ea(8'h84, {2'h3, j[2:0], 3'h6}))
         `CHK(extra_clock, 1'(j != 4))
         `CHK(ea_undefined, 1'(j == 4))
         `CHK(seg_is_ss, 1'h0)
         `CHK(disp_size, SIBAD_DISP_DWORD)
         `CHK(scale_factor, 4'h8)
      end
      $display("t_index done");
   endtask
   task automatic t_form();
      go(8'h04, 8'h8d);
      `CHK(ea_offset, (gpr[1] << 2) + dword_disp)
      `CHK(has_base, 1'h0)
      `CHK(extra_clock, 1'h0)
      `CHK(seg_is_ss, 1'h0)
      `CHK(scale_factor, 4'h4)
      go(8'hc4, 8'h0c);
      `CHK(sib_present, 1'h0)
      `CHK(has_index, 1'h0)
      `CHK(ea_offset, gpr[4])
      `CHK(scale_factor, 4'h1)
      `CHK(extra_clock, 1'h0)
      go(8'h05, 8'h0c);
      `CHK(sib_present, 1'h0)
      `CHK(ea_offset, dword_disp)
      `CHK(disp_size, SIBAD_DISP_DWORD)
      $display("t_form done");
   endtask
   task automatic t_reset();
      go(8'h44, 8'hc8);
      @(posedge ref_clk) #1;
      reset = 1'h1;
      req_valid = 1'h1;
      repeat (2) @(posedge ref_clk);
      #1;
      `CHK(out_valid, 1'h0)
      `CHK(ea_offset, SIBAD_ZERO32)
      `CHK(scale_factor, 4'h1)
      `CHK(sib_present, 1'h0)
      `CHK(extra_clock, 1'h0)
      `CHK(seg_is_ss, 1'h0)
      reset = 1'h0;
      req_valid = 1'h0;
      go(8'h44, 8'h88);
      `CHK(ea_offset, ea(8'h44, 8'h88))
      $display("t_reset done");
   endtask
   task automatic t_misc();
      go(8'h45, 8'h00);
      `CHK(sib_present, 1'h0)
      `CHK(ea_offset, gpr[5] - 32'h0000_0004)
      go(8'h04, 8'h60);
      `CHK(ea_undefined, 1'h1)
      @(posedge ref_clk) #1;
      `CHK(out_valid, 1'h0)
      `CHK(ea_undefined, 1'h1)
      $display("t_misc done");
   endtask
   task automatic report_and_stop();
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge ref_clk);
      #1 reset = 1'h0;
      t_scale();
      t_base();
      t_misc();
      t_index();
      t_form();
      t_reset();
      report_and_stop();
   end
endmodule // sib_address_decode_tb_top
